// ### rtl/pin_port_ctrl.sv
// port pins, external and keyboard interrupt, reset pin pulldown and bus registers
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - device pulls reset pin low on any internal reset source.
// - interrupt pin triggers on falling edge, or edge plus low level, by option.
// - when interrupt enabled, falling edge on any keyboard line requests it.
// - keyboard line interrupts are always falling-edge only.
// - all port lines are inputs after reset; direction set by software.
// - converter off after reset; shared pins then read as digital inputs.
// - with converter on, selected pin reads zero, others read true level.
// - converter control bits select the single analogue input pin.
// - two upper second-port pins carry timer capture in and compare out.
// - low four second-port pins serve serial; next two serve pulse outputs.
module pin_port_ctrl
  import pin_port_pkg::*;
#(
  parameter bit LEVEL_SENSE = 1'b0
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output var  logic [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic [CAUSE_W-1:0]           reset_sources,
  input  wire logic                         reset_pin_in,
  output var  logic                         reset_pin_out,
  output var  logic                         reset_pin_oe,
  input  wire logic                         irq_pin_n,
  output var  logic                         cpu_irq,
  output logic                              irq,
  input  wire logic [FIRST_W-1:0]           first_port_lines_in,
  output var  logic [FIRST_W-1:0]           first_port_lines_out,
  output var  logic [FIRST_W-1:0]           first_port_lines_oe,
  input  wire logic [SECOND_W-1:0]          second_port_in,
  output var  logic [SECOND_W-1:0]          second_port_out,
  output var  logic [SECOND_W-1:0]          second_port_oe,
  input  wire logic [KEY_W-1:0]             keyboard_port_lines_in,
  output var  logic [KEY_W-1:0]             keyboard_port_lines_out,
  output var  logic [KEY_W-1:0]             keyboard_port_lines_oe,
  input  wire logic [CONV_W-1:0]            converter_shared_inputs,
  output var  logic                         converter_enable,
  output var  logic [2:0]                   converter_select,
  input  wire pin_port_pkg::periph_out_s    periph_out,
  input  wire logic                         serial_enable,
  input  wire logic                         pulse_a_enable,
  input  wire logic                         pulse_b_enable,
  input  wire logic                         compare_enable,
  output var  logic [3:0]                   serial_shared_lines_in,
  output var  logic                         timer_capture_in_line
);
  import pin_port_pkg::*;

  // output lines read back their latch, input lines the synchronised pin
  function automatic logic [7:0] read_back(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin);
    return (dir & latch) | (~dir & pin);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic                   irq_s;
  logic [KEY_W-1:0]       key_s;
  logic [FIRST_W-1:0]     first_s;
  logic [SECOND_W-1:0]    second_s;
  logic [CONV_W-1:0]      conv_s;
  logic                   rst_s;

  pin_sync #(.W(1 + KEY_W), .INIT('1)) u_sync_int (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({irq_pin_n, keyboard_port_lines_in}),
    .q       ({irq_s, key_s})
  );
  pin_sync #(.W(FIRST_W + SECOND_W + CONV_W + 1), .INIT('0)) u_sync_port (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({first_port_lines_in, second_port_in, converter_shared_inputs, reset_pin_in}),
    .q       ({first_s, second_s, conv_s, rst_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [FIRST_W-1:0]  first_data, first_dir, next_first_data, next_first_dir;
  logic [SECOND_W-1:0] second_data, second_dir, next_second_data, next_second_dir;
  logic [KEY_W-1:0]    key_data, key_dir, next_key_data, next_key_dir;
  logic [3:0]          conv_ctrl, next_conv_ctrl;
  logic                irq_en, next_irq_en;
  logic [1:0]          int_status, int_mask, next_int_status, next_int_mask;
  logic [CAUSE_W-1:0]  cause, next_cause;
  logic                irq_prev, next_irq_prev;
  logic [KEY_W-1:0]    key_prev, next_key_prev;
  logic                rst_prev, next_rst_prev;
  logic                pend, next_pend;
  logic [31:0]         next_hrdata;

  // address phase capture
  logic                dp_write, next_dp_write, next_dp_read;
  logic [7:0]          dp_addr, next_dp_addr;

  logic                irq_fall, key_fall, irq_low, ext_reset_seen;
  logic [CONV_W-1:0]   conv_read;
  logic [7:0]          wb;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(int_status & int_mask);
  assign wb        = hwdata[7:0];

  always_comb begin
    irq_fall       = irq_prev & ~irq_s;
    irq_low        = LEVEL_SENSE & ~irq_s;
    key_fall       = |(key_prev & ~key_s);
    ext_reset_seen = rst_prev & ~rst_s;
    conv_read      = conv_s;
    if (conv_ctrl[CONV_EN_BIT] && conv_ctrl[2:0] < 3'(CONV_W)) begin
      conv_read[conv_ctrl[2:0]] = 1'b0;
    end
  end

  always_comb begin
    next_first_data  = first_data;
    next_first_dir   = first_dir;
    next_second_data = second_data;
    next_second_dir  = second_dir;
    next_key_data    = key_data;
    next_key_dir     = key_dir;
    next_conv_ctrl   = conv_ctrl;
    next_irq_en      = irq_en;
    next_int_mask    = int_mask;
    next_int_status  = int_status;
    next_cause       = cause | reset_sources;
    next_irq_prev    = irq_s;
    next_key_prev    = key_s;
    next_rst_prev    = rst_s;
    next_dp_write    = hsel & hready & htrans[1] & hwrite;
    next_dp_read     = hsel & hready & htrans[1] & ~hwrite;
    next_dp_addr     = haddr[7:0];
    next_hrdata      = 32'h0000_0000;
    // cpu request: edge latched, level held while low
    next_pend        = irq_en & (pend | irq_fall | key_fall);
    if (dp_write) begin
      case (dp_addr)
        OFF_FIRST_DATA:  next_first_data  = wb[FIRST_W-1:0];
        OFF_SECOND_DATA: next_second_data = wb;
        OFF_KEY_DATA:    next_key_data    = wb;
        OFF_FIRST_DIR:   next_first_dir   = wb[FIRST_W-1:0];
        OFF_SECOND_DIR:  next_second_dir  = wb;
        OFF_KEY_DIR:     next_key_dir     = wb;
        OFF_CONV_CTRL:   next_conv_ctrl   = wb[3:0];
        OFF_IRQ_CTRL: begin
          next_irq_en = wb[IRQ_EN_BIT];
          // ack clears the latched edge, but an edge in the same cycle wins
          if (wb[1]) next_pend = irq_en & (irq_fall | key_fall);
        end
        OFF_INT_MASK:    next_int_mask    = wb[1:0];
        OFF_INT_STATUS:  next_int_status  = int_status & ~wb[1:0];
        OFF_RESET_CAUSE: next_cause       = (cause & ~wb[CAUSE_W-1:0]) | reset_sources;
        default: ;
      endcase
    end
    // set beats clear
    if (irq_en && (irq_fall || key_fall || irq_low)) next_int_status[ST_IRQ_BIT] = 1'b1;
    if (ext_reset_seen) next_int_status[ST_RESET_BIT] = 1'b1;
    if (next_dp_read) begin
      case (haddr[7:0])
        OFF_FIRST_DATA:  next_hrdata[7:0] = read_back({1'b0, first_dir}, {1'b0, first_data},
                                                      {1'b0, first_s});
        OFF_SECOND_DATA: next_hrdata[7:0] = read_back(second_dir, second_data, second_s);
        OFF_KEY_DATA:    next_hrdata[7:0] = read_back(key_dir, key_data, key_s);
        OFF_CONV_DATA:   next_hrdata[7:0] = {3'b000, conv_read};
        OFF_FIRST_DIR:   next_hrdata[7:0] = {1'b0, first_dir};
        OFF_SECOND_DIR:  next_hrdata[7:0] = second_dir;
        OFF_KEY_DIR:     next_hrdata[7:0] = key_dir;
        OFF_CONV_CTRL:   next_hrdata[7:0] = {4'h0, conv_ctrl};
        OFF_IRQ_CTRL:    next_hrdata[7:0] = {5'b0, irq_s, pend, irq_en};
        OFF_INT_STATUS:  next_hrdata[7:0] = {6'b0, int_status};
        OFF_INT_MASK:    next_hrdata[7:0] = {6'b0, int_mask};
        OFF_RESET_CAUSE: next_hrdata[7:0] = {3'b0, cause};
        default:         next_hrdata      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_data  <= '0;
      first_dir   <= DIR_RESET[FIRST_W-1:0];
      second_data <= '0;
      second_dir  <= DIR_RESET;
      key_data    <= '0;
      key_dir     <= DIR_RESET;
      conv_ctrl   <= CONV_CTRL_RESET;
      irq_en      <= 1'b0;
      int_status  <= STATUS_RESET;
      int_mask    <= STATUS_RESET;
      cause       <= '0;
      irq_prev    <= 1'b1;
      key_prev    <= '1;
      rst_prev    <= 1'b0;                                   // matches sync reset: no false fall
      pend        <= 1'b0;
      dp_write    <= 1'b0;
      dp_addr     <= 8'h00;
      hrdata      <= 32'h0000_0000;
    end else begin
      first_data  <= next_first_data;
      first_dir   <= next_first_dir;
      second_data <= next_second_data;
      second_dir  <= next_second_dir;
      key_data    <= next_key_data;
      key_dir     <= next_key_dir;
      conv_ctrl   <= next_conv_ctrl;
      irq_en      <= next_irq_en;
      int_status  <= next_int_status;
      int_mask    <= next_int_mask;
      cause       <= next_cause;
      irq_prev    <= next_irq_prev;
      key_prev    <= next_key_prev;
      rst_prev    <= next_rst_prev;
      pend        <= next_pend;
      dp_write    <= next_dp_write;
      dp_addr     <= next_dp_addr;
      hrdata      <= next_hrdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_comb begin
    cpu_irq                 = pend | (irq_en & irq_low);
    reset_pin_out           = 1'b0;
    reset_pin_oe            = |reset_sources;
    first_port_lines_out    = first_data;
    first_port_lines_oe     = first_dir;
    keyboard_port_lines_out = key_data;
    keyboard_port_lines_oe  = key_dir;
    second_port_out         = second_data;
    second_port_oe          = second_dir;
    if (serial_enable) begin
      second_port_out[3:0] = periph_out.serial_out;
      second_port_oe[3:0]  = periph_out.serial_oe;
    end
    if (pulse_a_enable) begin
      second_port_out[PULSE_A_POS] = periph_out.pulse_a;
      second_port_oe[PULSE_A_POS]  = 1'b1;
    end
    if (pulse_b_enable) begin
      second_port_out[PULSE_B_POS] = periph_out.pulse_b;
      second_port_oe[PULSE_B_POS]  = 1'b1;
    end
    if (compare_enable) begin
      second_port_out[TCMP_POS] = periph_out.compare_out;
      second_port_oe[TCMP_POS]  = 1'b1;
    end
    serial_shared_lines_in  = second_s[3:0];
    timer_capture_in_line   = second_s[TCAP_POS];
    converter_enable        = conv_ctrl[CONV_EN_BIT];
    converter_select        = conv_ctrl[2:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  a_reset_pin_pull: assert property (@(posedge hclk) disable iff (!hresetn)
    |reset_sources |-> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not pulled low on internal reset");
  a_key_edge_req: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_en && key_fall) |=> cpu_irq)
    else $error("keyboard falling edge did not request interrupt");
  a_key_no_level: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pend && irq_s && !irq_fall && !key_fall) |-> !cpu_irq)
    else $error("keyboard low level raised interrupt");
  a_edge_mode_req: assert property (@(posedge hclk) disable iff (!hresetn)
    (!LEVEL_SENSE && !pend && !$past(irq_en && (irq_fall || key_fall))) |-> !cpu_irq)
    else $error("edge mode request without an edge");
  a_conv_sel_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (conv_ctrl[CONV_EN_BIT] && conv_ctrl[2:0] < 3'(CONV_W)) |->
      conv_read[conv_ctrl[2:0]] == 1'b0)
    else $error("selected analogue pin did not read zero");
  a_conv_off_true: assert property (@(posedge hclk) disable iff (!hresetn)
    !conv_ctrl[CONV_EN_BIT] |-> conv_read == conv_s)
    else $error("disabled converter altered digital read");
  a_dir_after_rst: assert property (@(posedge hclk)
    $rose(hresetn) |-> first_dir == '0 && second_dir == '0 && key_dir == '0 && !converter_enable)
    else $error("port line set as output right after reset");
  a_capture_route: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_capture_in_line == second_s[TCAP_POS])
    else $error("capture input not routed");
  a_sync_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    ##2 (key_s == $past(keyboard_port_lines_in, 2)))
    else $error("keyboard input not two-flop synchronised");
  a_pulse_route: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_a_enable |-> second_port_oe[PULSE_A_POS] && second_port_out[PULSE_A_POS]
      == periph_out.pulse_a)
    else $error("pulse output a not routed");
endmodule // pin_port_ctrl
`default_nettype wire

// ### include/pin_port_pkg.sv
// shared constants, register map and carriers for the pin and port block
`default_nettype none
package pin_port_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_FIRST_DATA   = 8'h00;
  localparam logic [7:0] OFF_SECOND_DATA  = 8'h04;
  localparam logic [7:0] OFF_KEY_DATA     = 8'h08;
  localparam logic [7:0] OFF_CONV_DATA    = 8'h0C;
  localparam logic [7:0] OFF_FIRST_DIR    = 8'h10;
  localparam logic [7:0] OFF_SECOND_DIR   = 8'h14;
  localparam logic [7:0] OFF_KEY_DIR      = 8'h18;
  localparam logic [7:0] OFF_CONV_CTRL    = 8'h1C;
  localparam logic [7:0] OFF_IRQ_CTRL     = 8'h20;
  localparam logic [7:0] OFF_INT_STATUS   = 8'h24;
  localparam logic [7:0] OFF_INT_MASK     = 8'h28;
  localparam logic [7:0] OFF_RESET_CAUSE  = 8'h2C;
  // field positions
  localparam int CONV_EN_BIT      = 3;
  localparam int CONV_SEL_LSB     = 0;
  localparam int IRQ_EN_BIT       = 0;
  localparam int ST_IRQ_BIT       = 0;
  localparam int ST_RESET_BIT     = 1;
  // widths and reset values
  localparam int FIRST_W  = 7;
  localparam int SECOND_W = 8;
  localparam int KEY_W    = 8;
  localparam int CONV_W   = 5;
  localparam int CAUSE_W  = 5;
  localparam logic [7:0]  DIR_RESET       = 8'h00;
  localparam logic [3:0]  CONV_CTRL_RESET = 4'h0;
  localparam logic [1:0]  STATUS_RESET    = 2'h0;
  // second port pin positions of shared functions
  localparam int PULSE_A_POS = 4;
  localparam int PULSE_B_POS = 5;
  localparam int TCMP_POS    = 6;
  localparam int TCAP_POS    = 7;
  // internal reset source indices
  localparam int RC_WATCHDOG = 0;
  localparam int RC_POWER_ON = 1;
  localparam int RC_ILLEGAL  = 2;
  localparam int RC_STOP     = 3;
  localparam int RC_LOW_VOLT = 4;

  typedef struct packed {
    logic [3:0] serial_out;
    logic [3:0] serial_oe;
    logic       pulse_a;
    logic       pulse_b;
    logic       compare_out;
  } periph_out_s;
endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
// two-flop synchroniser for a vector of pin inputs
`default_nettype none
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### verification/pin_world.sv
// far-side pin model: pull-ups, outside drivers and the shared open-drain reset line
`default_nettype none
module pin_world
  import pin_port_pkg::*;
(
  input  wire logic [FIRST_W-1:0]  f_out,
  input  wire logic [FIRST_W-1:0]  f_oe,
  input  wire logic [FIRST_W-1:0]  f_ext,
  output var  logic [FIRST_W-1:0]  f_in,
  input  wire logic [SECOND_W-1:0] s_out,
  input  wire logic [SECOND_W-1:0] s_oe,
  input  wire logic [SECOND_W-1:0] s_ext,
  output var  logic [SECOND_W-1:0] s_in,
  input  wire logic [KEY_W-1:0]    k_out,
  input  wire logic [KEY_W-1:0]    k_oe,
  input  wire logic [KEY_W-1:0]    k_ext,
  output var  logic [KEY_W-1:0]    k_in,
  input  wire logic                irq_low,
  output var  logic                irq_n,
  input  wire logic                rst_oe,
  input  wire logic                rst_out,
  input  wire logic                rst_low,
  output var  logic                rst_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ext at 1 means nothing outside drives: the pull-up wins
  assign f_in = (f_oe & f_out) | (~f_oe & f_ext);
  assign s_in = (s_oe & s_out) | (~s_oe & s_ext);
  assign k_in = (k_oe & k_out) | (~k_oe & k_ext);
  // pin idles high through its resistor unless a switch pulls it down
  assign irq_n = ~irq_low;
  // wired low: device pulldown or outside switch beats the pull-up
  assign rst_in = ~((rst_oe & ~rst_out) | rst_low);
endmodule // pin_world
`default_nettype wire

// ### verification/pin_interrupt_and_port_defaults_tb.sv
// self-checking bench for the pin, port and interrupt block
`default_nettype none
module pin_interrupt_and_port_defaults_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_port_pkg::*;
  logic               hclk, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0]        haddr = '0, hwdata = '0, hrdata;
  logic [1:0]         htrans = 2'b00;
  logic [2:0]         hsize = 3'b010;
  logic [CAUSE_W-1:0] reset_sources = '0;
  logic               rst_in, rst_oe, rst_out, rst_low = 1'b0, irq_low = 1'b0;
  logic               irq_n, cpu_irq, lvl_irq, irq, conv_en, cap_in;
  logic               ser_en = 1'b0, pa_en = 1'b0, pb_en = 1'b0, cmp_en = 1'b0;
  logic [FIRST_W-1:0] f_in, f_out, f_oe, f_ext = 7'h7f;
  logic [7:0]         s_in, s_out, s_oe, k_in, k_out, k_oe, s_ext = 8'hff, k_ext = 8'hff;
  logic [CONV_W-1:0]  conv_in = '0;
  logic [2:0]         conv_sel;
  logic [3:0]         ser_in;
  periph_out_s        po = '0;
  int                 mismatches = 0, total_checks = 0;

  pin_port_ctrl #(.LEVEL_SENSE(1'b0)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reset_sources(reset_sources),
    .reset_pin_in(rst_in), .reset_pin_out(rst_out), .reset_pin_oe(rst_oe),
    .irq_pin_n(irq_n), .cpu_irq(cpu_irq), .irq(irq), .first_port_lines_in(f_in),
    .first_port_lines_out(f_out), .first_port_lines_oe(f_oe), .second_port_in(s_in),
    .second_port_out(s_out), .second_port_oe(s_oe), .keyboard_port_lines_in(k_in),
    .keyboard_port_lines_out(k_out), .keyboard_port_lines_oe(k_oe),
    .converter_shared_inputs(conv_in), .converter_enable(conv_en),
    .converter_select(conv_sel), .periph_out(po), .serial_enable(ser_en),
    .pulse_a_enable(pa_en), .pulse_b_enable(pb_en), .compare_enable(cmp_en),
    .serial_shared_lines_in(ser_in), .timer_capture_in_line(cap_in)
  );

  // level-sensitive build sharing every input with dut; only its request is watched
  pin_port_ctrl #(.LEVEL_SENSE(1'b1)) dut_level (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(),
    .hreadyout(), .hresp(), .reset_sources(reset_sources), .reset_pin_in(rst_in),
    .reset_pin_out(), .reset_pin_oe(), .irq_pin_n(irq_n), .cpu_irq(lvl_irq), .irq(),
    .first_port_lines_in(f_in), .first_port_lines_out(), .first_port_lines_oe(),
    .second_port_in(s_in), .second_port_out(), .second_port_oe(),
    .keyboard_port_lines_in(k_in), .keyboard_port_lines_out(), .keyboard_port_lines_oe(),
    .converter_shared_inputs(conv_in), .converter_enable(), .converter_select(),
    .periph_out(po), .serial_enable(ser_en), .pulse_a_enable(pa_en),
    .pulse_b_enable(pb_en), .compare_enable(cmp_en), .serial_shared_lines_in(),
    .timer_capture_in_line()
  );

  pin_world far_side (
    .f_out(f_out), .f_oe(f_oe), .f_ext(f_ext), .f_in(f_in), .s_out(s_out), .s_oe(s_oe),
    .s_ext(s_ext), .s_in(s_in), .k_out(k_out), .k_oe(k_oe), .k_ext(k_ext), .k_in(k_in),
    .irq_low(irq_low), .irq_n(irq_n), .rst_oe(rst_oe), .rst_out(rst_out),
    .rst_low(rst_low), .rst_in(rst_in)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // no wait state is assumed: the loop only bounds a hang
  task automatic wait_ready();
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) begin
        return;
      end
    end
    mismatches++;
    $display("ERROR %0t bus ready never seen", $time);
    finish_test();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, exp, what);
  endtask

  task automatic expect_irq(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge hclk);
      if (cpu_irq === 1'b1) seen = 1'b1;
    end
    check({31'h0, seen}, {31'h0, exp}, "cpu irq");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    check({8'h00, conv_en, f_oe, s_oe, k_oe}, 32'h0000_0000, "oe after reset");
    rd_chk(OFF_FIRST_DIR, 32'h0000_0000, "first dir");
    rd_chk(OFF_SECOND_DIR, 32'h0000_0000, "second dir");
    rd_chk(OFF_KEY_DIR, 32'h0000_0000, "key dir");
    rd_chk(OFF_CONV_CTRL, 32'h0000_0000, "conv ctrl");
    rd_chk(OFF_IRQ_CTRL, 32'h0000_0004, "irq pin idle");
    conv_in <= 5'h16;
    f_ext <= 7'h35;
    repeat (3) @(posedge hclk);
    rd_chk(OFF_CONV_DATA, 32'h0000_0016, "conv pins as inputs");
    rd_chk(OFF_FIRST_DATA, 32'h0000_0035, "first pins as inputs");
    wr(8'h30, 32'h0000_00ff);
    rd_chk(8'h30, 32'h0000_0000, "unmapped place");
    check({31'h0, hresp}, 32'h0000_0000, "response code");
  endtask

  task automatic t_direction();
    wr(OFF_FIRST_DIR, 32'h0000_007f);
    wr(OFF_FIRST_DATA, 32'h0000_002a);
    wr(OFF_KEY_DATA, 32'h0000_005c);
    wr(OFF_KEY_DIR, 32'h0000_00ff);
    @(posedge hclk);
    check({11'h000, f_oe, f_out, k_oe[6:0]}, {11'h000, 7'h7f, 7'h2a, 7'h7f}, "drive");
    check({24'h00_0000, k_out}, 32'h0000_005c, "key latch out");
    rd_chk(OFF_FIRST_DATA, 32'h0000_002a, "first latch");
    wr(OFF_FIRST_DIR, 32'h0000_0000);
    wr(OFF_KEY_DIR, 32'h0000_0000);
  endtask

  task automatic t_converter();
    conv_in <= 5'h1f;
    for (int s = 0; s < 6; s++) begin
      wr(OFF_CONV_CTRL, 32'h0000_0008 | 32'(s));
      @(posedge hclk);
      check({28'h000_0000, conv_en, conv_sel}, 32'h0000_0008 | 32'(s), "conv route");
      rd_chk(OFF_CONV_DATA, (s < 5) ? 32'h0000_001f & ~(32'h0000_0001 << s)
             : 32'h0000_001f, "conv read");
    end
    wr(OFF_CONV_CTRL, 32'h0000_0000);
  endtask

  task automatic t_shared();
    po <= {4'ha, 4'hf, 1'b1, 1'b1, 1'b1};
    ser_en <= 1'b1;
    pa_en <= 1'b1;
    pb_en <= 1'b1;
    cmp_en <= 1'b1;
    s_ext <= 8'h7f;
    repeat (3) @(posedge hclk);
    check({18'h0_0000, s_out[6:0], s_oe[6:0]}, {18'h0_0000, 7'h7a, 7'h7f}, "shared");
    check({28'h000_0000, ser_in}, 32'h0000_000a, "serial in");
    check({31'h0, cap_in}, 32'h0000_0000, "capture low");
    s_ext <= 8'hff;
    ser_en <= 1'b0;
    pa_en <= 1'b0;
    pb_en <= 1'b0;
    cmp_en <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, cap_in}, 32'h0000_0001, "capture high");
    check({24'h00_0000, s_oe}, 32'h0000_0000, "shared released");
  endtask

  task automatic t_irq_pin();
    wr(OFF_IRQ_CTRL, 32'h0000_0001);
    wr(OFF_INT_MASK, 32'h0000_0001);
    irq_low <= 1'b1;
    repeat (2) @(posedge hclk);
    check({31'h0, cpu_irq}, 32'h0000_0000, "irq before sync");
    expect_irq(1'b1);
    check({31'h0, irq}, 32'h0000_0001, "irq line");
    rd_chk(OFF_INT_STATUS, 32'h0000_0001, "status set");
    wr(OFF_IRQ_CTRL, 32'h0000_0003);
    wr(OFF_INT_STATUS, 32'h0000_0001);
    expect_irq(1'b0);
    check({31'h0, irq}, 32'h0000_0000, "irq cleared");
    check({31'h0, lvl_irq}, 32'h0000_0001, "level build held");
    irq_low <= 1'b0;
    repeat (4) @(posedge hclk);
    check({31'h0, lvl_irq}, 32'h0000_0000, "level build released");
    wr(OFF_INT_MASK, 32'h0000_0000);
    irq_low <= 1'b1;
    expect_irq(1'b1);
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(OFF_IRQ_CTRL, 32'h0000_0000);
    wr(OFF_INT_STATUS, 32'h0000_0001);
    irq_low <= 1'b0;
    repeat (4) @(posedge hclk);
    irq_low <= 1'b1;
    expect_irq(1'b0);
    irq_low <= 1'b0;
    wr(OFF_IRQ_CTRL, 32'h0000_0003);
  endtask

  // line held low after the ack must not ask again
  task automatic t_keyboard();
    for (int i = 0; i < KEY_W; i++) begin
      k_ext <= ~(8'h01 << i);
      expect_irq(1'b1);
      wr(OFF_IRQ_CTRL, 32'h0000_0003);
      expect_irq(1'b0);
      check({31'h0, lvl_irq}, 32'h0000_0000, "level build key");
      k_ext <= 8'hff;
      repeat (4) @(posedge hclk);
    end
    wr(OFF_INT_STATUS, 32'h0000_0003);
  endtask

  task automatic t_reset_pin();
    for (int i = 0; i < CAUSE_W; i++) begin
      reset_sources <= 5'h01 << i;
      @(posedge hclk);
      check({30'h0, rst_oe, rst_out}, 32'h0000_0002, "reset pulled low");
      reset_sources <= 5'h00;
      @(posedge hclk);
      check({31'h0, rst_oe}, 32'h0000_0000, "reset released");
    end
    repeat (3) @(posedge hclk);
    rd_chk(OFF_RESET_CAUSE, 32'h0000_001f, "cause sticky");
    rd_chk(OFF_INT_STATUS, 32'h0000_0002, "pin fall seen");
    wr(OFF_RESET_CAUSE, 32'h0000_001f);
    wr(OFF_INT_STATUS, 32'h0000_0003);
    rst_low <= 1'b1;
    repeat (4) @(posedge hclk);
    rst_low <= 1'b0;
    repeat (4) @(posedge hclk);
    rd_chk(OFF_INT_STATUS, 32'h0000_0002, "outside reset seen");
    rd_chk(OFF_RESET_CAUSE, 32'h0000_0000, "no inside cause");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults();
    t_direction();
    t_converter();
    t_shared();
    t_irq_pin();
    t_keyboard();
    t_reset_pin();
    finish_test();
  end
endmodule // pin_interrupt_and_port_defaults_tb
`default_nettype wire
